// *** inc/vts_pkg.sv ***
// Notes on behaviour
// - Line 0 base; expanded: inputs 0-3, outputs 4-7
// - Input types: rising, falling, level high default
// - Base: immediate edges; expanded: edges at vblank
// - State read: bits 0-3 inputs, 4-7 outputs
// - Debounce locks line until untriggered at vblank
// - Per-line filter length and both-edge option, readable
// - Wait-any stalls until one masked line matches
// - Wait-all stalls while any masked line differs
// - Compare states to requested bits under mask
// - Switch gets highest set line; clear per mode
// - Switch value picks frame and video input
// - Board reset clears switch value
// - Direct write drives masked lines; zero mask fails
// - Direct write mask on input clears its latch
// - Lines 4-7 accept only output type
// - Line-synced pulse at programmed line, every field
// - Trigger-fired pulse starts immediately on edge
// - Per-line pulse length; line 7 twin pulse gap
// - Holdoff delays one-shot and trigger pulses only
// - Init: no sync/twin, 17 lines, holdoff 9/8
// - One-shot command emits one pulse (twin pair on line 7), holdoff applies
package vts_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } vts_apb_req_t;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic vblank;
    logic field;
  } vts_video_t;

  typedef struct packed {
    logic       valid;
    logic       all;
    logic [3:0] state;
    logic [3:0] mask;
  } vts_wait_t;

  // =====================================
  // Register offsets
  localparam logic [7:0] VTS_CTRL      = 8'h00;
  localparam logic [7:0] VTS_TYPE      = 8'h04;
  localparam logic [7:0] VTS_STATES    = 8'h08;
  localparam logic [7:0] VTS_FILTER    = 8'h0c;
  localparam logic [7:0] VTS_SELECTOR  = 8'h10;
  localparam logic [7:0] VTS_ONE_SHOT  = 8'h14;
  localparam logic [7:0] VTS_SYNC      = 8'h18;
  localparam logic [7:0] VTS_TRIG      = 8'h1c;
  localparam logic [7:0] VTS_PLEN      = 8'h20;
  localparam logic [7:0] VTS_TWIN      = 8'h24;
  localparam logic [7:0] VTS_HMASK     = 8'h28;
  localparam logic [7:0] VTS_HSTART    = 8'h2c;
  localparam logic [7:0] VTS_HLEN      = 8'h30;

  // =====================================
  // Field positions
  localparam int unsigned VTS_CTRL_EXP  = 0;
  localparam int unsigned VTS_CTRL_RST  = 1;
  localparam int unsigned VTS_DW_MASK   = 8;
  localparam int unsigned VTS_FLT_BOTH  = 4;
  localparam int unsigned VTS_FLT_LEN   = 8;
  localparam int unsigned VTS_SYNC_LINE = 16;
  localparam int unsigned VTS_TRIG_SRC  = 4;
  localparam int unsigned VTS_TWIN_GAP  = 8;
  localparam int unsigned VTS_HST1      = 16;

  // =====================================
  // Line types
  localparam logic [1:0] VTS_TY_LEVEL = 2'h0;
  localparam logic [1:0] VTS_TY_RISE  = 2'h1;
  localparam logic [1:0] VTS_TY_FALL  = 2'h2;
  localparam logic [1:0] VTS_TY_OUT   = 2'h3;

  // =====================================
  // Timing and reset values
  localparam int unsigned VTS_LINE_NS   = 64000;
  localparam int unsigned VTS_PULSE_NS  = 1088000;
  localparam logic [7:0]  VTS_PLEN_RST  = 8'(VTS_PULSE_NS / VTS_LINE_NS);
  localparam logic [15:0] VTS_TYPE_RST  = 16'hff00;
  localparam logic [9:0]  VTS_HST0_RST  = 10'h009;
  localparam logic [9:0]  VTS_HST1_RST  = 10'h008;
  localparam logic [7:0]  VTS_HLEN_RST  = 8'h01;
  localparam logic [3:0]  VTS_HMASK_RST = 4'hf;
  localparam logic [3:0]  VTS_FLEN_RST  = 4'h0;
  localparam logic        VTS_EXP_RST   = 1'b1;

endpackage

// *** hdl/vts_io.sv ***
// Our own choices: the register offsets and the APB register port.
module vts_io (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 clk_en,
  input  vts_pkg::vts_apb_req_t     apb_req,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  vts_pkg::vts_video_t       video,
  input  wire logic [3:0]           trig_in,
  input  vts_pkg::vts_wait_t        wait_head,
  output logic                      wait_done,
  output logic [1:0]                selector_value,
  output logic [3:0]                strobe_out
);
  import vts_pkg::*;

  // =====================================
  // State
  logic        expanded_q;
  logic [15:0] type_q;
  logic [3:0]  flt_en_q;
  logic [3:0]  flt_both_q;
  logic [15:0] flt_len_q;

  // Strobe setup
  logic [3:0]  sync_en_q;
  logic [9:0]  sync_line_q;
  logic [3:0]  arm_q;
  logic [1:0]  arm_src_q;
  logic [31:0] plen_q;
  logic        twin_en_q;
  logic [7:0]  gap_q;
  logic [3:0]  hmask_q;
  logic [9:0]  hst0_q;
  logic [9:0]  hst1_q;
  logic [7:0]  hlen_q;

  // Input tracking, video timing and queue
  logic [3:0]  latch_q;
  logic [3:0]  lock_q;
  logic [15:0] lcnt_q;
  logic [3:0]  prev_q;
  logic [3:0]  vbs_q;
  logic [1:0]  sel_q;
  logic [9:0]  line_q;
  logic        hs_q;
  logic        vs_q;
  logic        vb_q;
  logic        done_q;
  logic [3:0]  out_q;

  // Bus answer, always one wait state
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  // =====================================
  // Helpers
  // Highest set line wins; 0 when none is set
  function automatic logic [1:0] hi_idx(input logic [3:0] v);
    hi_idx = v[3] ? 2'd3 : v[2] ? 2'd2 : v[1] ? 2'd1 : 2'd0;
  endfunction

  // Inputs may not be outputs, outputs may be nothing else
  function automatic logic types_ok(input logic [15:0] t);
    types_ok = 1'b1;
    for (int k = 0; k < 8; k++) begin
      if ((k < 4) == (t[2*k +: 2] == VTS_TY_OUT)) begin
        types_ok = 1'b0;
      end
    end
  endfunction

  // =====================================
  // Video timing
  // One-cycle ticks on the rising sync levels
  wire hs_tick = video.hsync & ~hs_q;
  wire vs_tick = video.vsync & ~vs_q;
  wire vb_tick = video.vblank & ~vb_q;

  // Window end one bit wider so start plus length cannot wrap
  wire [9:0]  hst    = video.field ? hst1_q : hst0_q;
  wire [10:0] hend   = 11'(hst) + 11'(hlen_q);
  wire        in_hold = (line_q >= hst) && (11'(line_q) < hend);

  // =====================================
  // APB decode
  wire [7:0]  ad      = apb_req.paddr;
  wire [31:0] wd      = apb_req.pwdata;
  wire        access  = apb_req.psel & apb_req.penable;
  wire        is_wr   = apb_req.pwrite;
  // Writes land on the answer edge; refused ones never land
  wire        wr_fire = access & is_wr & pready_q & ~pslverr_q;
  wire        mapped  = (ad[1:0] == 2'b00) && (ad <= VTS_HLEN);
  wire        exp_reg = (ad == VTS_FILTER) || (ad == VTS_ONE_SHOT) || (ad == VTS_SYNC) ||
                        (ad == VTS_TRIG) || (ad == VTS_PLEN) || (ad == VTS_TWIN) ||
                        (ad == VTS_HMASK) || (ad == VTS_HSTART) || (ad == VTS_HLEN);
  wire        bad_wr  = is_wr && (((ad == VTS_TYPE) && !types_ok(wd[15:0])) ||
                        ((ad == VTS_STATES) && (wd[VTS_DW_MASK +: 8] == 8'h00)) ||
                        (exp_reg && !expanded_q));
  wire        err     = !mapped || bad_wr;
  // Board reset self-clears: it lives for one cycle only
  wire        soft_rst = wr_fire & (ad == VTS_CTRL) & wd[VTS_CTRL_RST];
  wire        dw_fire  = wr_fire & (ad == VTS_STATES);
  wire [7:0]  dw_mask  = wd[VTS_DW_MASK +: 8];

  // =====================================
  // Input lines
  wire [3:0] avail = expanded_q ? 4'hf : 4'h1;
  logic [3:0] state_live;
  logic [3:0] fire_ev;
  logic [3:0] clr_vec;

  // Level lines read live; edge lines latch until cleared
  for (genvar i = 0; i < 4; i++) begin : g_in
    wire [1:0] typ     = type_q[2*i +: 2];
    wire       is_lvl  = (typ == VTS_TY_LEVEL);
    wire       rise    = trig_in[i] & ~prev_q[i];
    wire       fall    = ~trig_in[i] & prev_q[i];
    wire       vrise   = vb_tick & trig_in[i] & ~vbs_q[i];
    wire       vfall   = vb_tick & ~trig_in[i] & vbs_q[i];
    wire       edge_now = (typ == VTS_TY_RISE) ? rise : (typ == VTS_TY_FALL) ? fall : 1'b0;
    wire       edge_vb  = (typ == VTS_TY_RISE) ? vrise : (typ == VTS_TY_FALL) ? vfall : 1'b0;
    wire       enabled  = avail[i] & ~lock_q[i];
    wire       detect   = enabled & (expanded_q ? edge_vb : edge_now);
    wire       untrig   = (typ == VTS_TY_FALL) ? trig_in[i] : ~trig_in[i];
    wire       filt_on  = expanded_q & flt_en_q[i];
    wire [3:0] flen     = flt_len_q[4*i +: 4];

    assign state_live[i] = is_lvl ? (enabled & trig_in[i]) : latch_q[i];
    // Strobe trigger uses the raw edge, not the vblank-sampled one
    assign fire_ev[i] = enabled & (is_lvl ? rise : edge_now);

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        latch_q[i]       <= 1'b0;
        lock_q[i]        <= 1'b0;
        lcnt_q[4*i +: 4] <= VTS_FLEN_RST;
        prev_q[i]        <= 1'b0;
        vbs_q[i]         <= 1'b0;
      end else if (clk_en) begin
        prev_q[i] <= trig_in[i];
        if (vb_tick) begin
          vbs_q[i] <= trig_in[i];
        end
        // A new detection wins over a clear in the same cycle
        latch_q[i] <= ~is_lvl & (detect | (latch_q[i] & ~clr_vec[i]));
        // Lock starts on the acknowledge of a set line
        if (soft_rst) begin
          lock_q[i] <= 1'b0;
        end else if (filt_on && clr_vec[i] && state_live[i]) begin
          lock_q[i]        <= 1'b1;
          lcnt_q[4*i +: 4] <= flen;
        end else if (lock_q[i] && vb_tick) begin
          // Each quiet vblank counts the extra filter length down
          if (untrig) begin
            if (lcnt_q[4*i +: 4] == 4'h0) begin
              lock_q[i] <= 1'b0;
            end else begin
              lcnt_q[4*i +: 4] <= lcnt_q[4*i +: 4] - 4'h1;
            end
          end else if (flt_both_q[i]) begin
            lcnt_q[4*i +: 4] <= flen;
          end
        end
      end
    end
  end

  // =====================================
  // Queue wait
  wire [3:0] wmatch   = ~(state_live ^ wait_head.state) & wait_head.mask;
  wire       any_hit  = |wmatch;
  wire       all_hit  = (wmatch == wait_head.mask);
  // Blocked in the cycle after a hit, so one head entry
  // cannot be answered twice
  wire       hit      = wait_head.valid & ~done_q & (wait_head.all ? all_hit : any_hit);
  wire [3:0] set_seen = state_live & wait_head.mask;
  wire [1:0] hi       = hi_idx(set_seen);
  wire [3:0] any_clr  = (set_seen != 4'h0) ? (4'h1 << hi) : 4'h0;
  wire [3:0] wait_clr = hit ? (wait_head.all ? wait_head.mask : any_clr) : 4'h0;
  assign clr_vec = wait_clr | (dw_fire ? dw_mask[3:0] : 4'h0) | {4{soft_rst}};

  // =====================================
  // Strobe outputs
  for (genvar j = 0; j < 4; j++) begin : g_out
    logic       act_q;
    logic       pend_q;
    logic [1:0] ph_q;
    logic [7:0] cnt_q;
    wire  [7:0] plen     = plen_q[8*j +: 8];
    wire        one_shot = wr_fire & (ad == VTS_ONE_SHOT) & wd[j];
    wire        trg      = arm_q[j] & fire_ev[arm_src_q];
    wire        holding  = hmask_q[j] & in_hold;
    wire        sync_hit = sync_en_q[j] & hs_tick & (line_q == sync_line_q);
    // A request inside the window waits in pend_q until it closes
    wire        req      = one_shot | trg;
    wire        start    = sync_hit | ((req | pend_q) & ~holding);
    wire        twin     = (j == 3) && twin_en_q;

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        act_q    <= 1'b0;
        pend_q   <= 1'b0;
        ph_q     <= 2'd0;
        cnt_q    <= 8'h00;
        out_q[j] <= 1'b0;
      end else if (clk_en) begin
        pend_q <= ~soft_rst & ~start & (pend_q | (req & holding));
        if (soft_rst) begin
          act_q    <= 1'b0;
          out_q[j] <= 1'b0;
        end else if (start) begin
          act_q    <= 1'b1;
          out_q[j] <= 1'b1;
          ph_q     <= 2'd0;
          cnt_q    <= plen;
        end else if (act_q && hs_tick) begin
          // Counts are in video lines, not clocks
          if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (twin && ph_q == 2'd0) begin
            ph_q     <= 2'd1;
            out_q[j] <= 1'b0;
            cnt_q    <= gap_q;
          end else if (ph_q == 2'd1) begin
            ph_q     <= 2'd2;
            out_q[j] <= 1'b1;
            cnt_q    <= plen;
          end else begin
            act_q    <= 1'b0;
            out_q[j] <= 1'b0;
          end
        end else if (dw_fire && dw_mask[4+j] && !act_q) begin
          // A running pulse wins over a direct write
          out_q[j] <= wd[4+j];
        end
      end
    end
  end

  // =====================================
  // Read mux
  // Write-only and unmapped words read as zero
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0;
    unique case (ad)
      VTS_CTRL:     rdata = {31'h0, expanded_q};
      VTS_TYPE:     rdata = {16'h0, type_q};
      VTS_STATES:   rdata = {24'h0, out_q, state_live};
      VTS_FILTER:   rdata = {8'h0, flt_len_q, flt_both_q, flt_en_q};
      VTS_SELECTOR: rdata = {30'h0, sel_q};
      VTS_SYNC:     rdata = {6'h0, sync_line_q, 12'h0, sync_en_q};
      VTS_TRIG:     rdata = {26'h0, arm_src_q, arm_q};
      VTS_PLEN:     rdata = plen_q;
      VTS_TWIN:     rdata = {16'h0, gap_q, 7'h0, twin_en_q};
      VTS_HMASK:    rdata = {28'h0, hmask_q};
      VTS_HSTART:   rdata = {6'h0, hst1_q, 6'h0, hst0_q};
      VTS_HLEN:     rdata = {24'h0, hlen_q};
      default:      rdata = 32'h0;
    endcase
  end

  // =====================================
  // Bus, video and misc state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
      hs_q      <= 1'b0;
      vs_q      <= 1'b0;
      vb_q      <= 1'b0;
      line_q    <= 10'h000;
      done_q    <= 1'b0;
      sel_q     <= 2'd0;
    end else if (clk_en) begin
      // One-cycle answer pulse; read data then holds
      pready_q  <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & err;
      if (access && !pready_q && !is_wr) begin
        prdata_q <= err ? 32'h0 : rdata;
      end

      hs_q <= video.hsync;
      vs_q <= video.vsync;
      vb_q <= video.vblank;
      if (vs_tick) begin
        line_q <= 10'h000;
      end else if (hs_tick) begin
        line_q <= line_q + 10'h001;
      end

      done_q <= hit;
      if (soft_rst) begin
        sel_q <= 2'd0;
      end else if (hit) begin
        sel_q <= hi;
      end
    end
  end

  // =====================================
  // Configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      expanded_q  <= VTS_EXP_RST;
      type_q      <= VTS_TYPE_RST;
      flt_en_q    <= 4'h0;
      flt_both_q  <= 4'h0;
      flt_len_q   <= {4{VTS_FLEN_RST}};
      sync_en_q   <= 4'h0;
      sync_line_q <= 10'h000;
      arm_q       <= 4'h0;
      arm_src_q   <= 2'd0;
      plen_q      <= {4{VTS_PLEN_RST}};
      twin_en_q   <= 1'b0;
      gap_q       <= 8'h00;
      hmask_q     <= VTS_HMASK_RST;
      hst0_q      <= VTS_HST0_RST;
      hst1_q      <= VTS_HST1_RST;
      hlen_q      <= VTS_HLEN_RST;
    end else if (clk_en) begin
      // Disarm after one fire; an arm written in the same cycle wins
      if (fire_ev[arm_src_q]) begin
        arm_q <= 4'h0;
      end

      if (soft_rst) begin
        arm_q     <= 4'h0;
        sync_en_q <= 4'h0;
      end else if (wr_fire) begin
        unique case (ad)
          VTS_CTRL:   expanded_q <= wd[VTS_CTRL_EXP];
          VTS_TYPE:   type_q <= wd[15:0];
          VTS_FILTER: begin
            flt_en_q   <= wd[3:0];
            flt_both_q <= wd[VTS_FLT_BOTH +: 4];
            flt_len_q  <= wd[VTS_FLT_LEN +: 16];
          end
          VTS_SYNC: begin
            sync_en_q   <= wd[3:0];
            sync_line_q <= wd[VTS_SYNC_LINE +: 10];
          end
          VTS_TRIG: begin
            arm_q     <= wd[3:0];
            arm_src_q <= wd[VTS_TRIG_SRC +: 2];
          end
          VTS_PLEN:   plen_q <= wd;
          VTS_TWIN: begin
            twin_en_q <= wd[0];
            gap_q     <= wd[VTS_TWIN_GAP +: 8];
          end
          VTS_HMASK:  hmask_q <= wd[3:0];
          VTS_HSTART: begin
            hst0_q <= wd[9:0];
            hst1_q <= wd[VTS_HST1 +: 10];
          end
          VTS_HLEN:   hlen_q <= wd[7:0];
          default:    hlen_q <= hlen_q;
        endcase
      end
    end
  end

  // Outputs come straight from flip-flops
  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign wait_done      = done_q;
  assign selector_value = sel_q;
  assign strobe_out     = out_q;

endmodule

// *** tb/vts_io_sva.sv ***
module vts_io_sva (
  input wire logic             clk,
  input wire logic             reset_n,
  input wire logic             clk_en,
  input vts_pkg::vts_apb_req_t apb_req,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input vts_pkg::vts_video_t   video,
  input wire logic [3:0]       trig_in,
  input vts_pkg::vts_wait_t    wait_head,
  input wire logic             wait_done,
  input wire logic [1:0]       selector_value,
  input wire logic [3:0]       strobe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import vts_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  wire logic acc = apb_req.psel && apb_req.penable;
  wire logic wr_done = acc && pready && apb_req.pwrite;

  // ========================================
  // Bus answer
  pready_wait_a: assert property (acc && !pready |=> pready)
    else $error("pready not one wait state");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready && acc)
    else $error("pslverr outside answer");
  bad_addr_a: assert property (acc && pready && apb_req.paddr > 8'h30 |-> pslverr)
    else $error("unmapped address accepted");
  zero_mask_a: assert property (
    wr_done && apb_req.paddr == VTS_STATES && apb_req.pwdata[15:8] == 8'h00 |-> pslverr)
    else $error("zero mask write accepted");
  out_type_a: assert property (
    wr_done && apb_req.paddr == VTS_TYPE && apb_req.pwdata[15:8] != 8'hff |-> pslverr)
    else $error("output line given input type");

  // ========================================
  // Wait queue and selector
  done_pulse_a: assert property (wait_done |=> !wait_done)
    else $error("wait_done longer than one cycle");
  done_cause_a: assert property ($rose(wait_done) |-> $past(wait_head.valid))
    else $error("wait_done without head");
  board_clear_a: assert property (
    wr_done && !pslverr && apb_req.paddr == VTS_CTRL && apb_req.pwdata[VTS_CTRL_RST]
    |=> selector_value == 2'h0)
    else $error("board reset kept selector");
  reset_clear_a: assert property (
    $rose(reset_n) |-> selector_value == 2'h0 && strobe_out == 4'h0)
    else $error("outputs not clear after reset");

  done_c: cover property (wait_done);
  err_c: cover property (pready && pslverr);
  twin_c: cover property ($rose(strobe_out[3]));
endmodule

bind vts_io vts_io_sva i_sva (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
  .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .video(video),
  .trig_in(trig_in), .wait_head(wait_head), .wait_done(wait_done),
  .selector_value(selector_value), .strobe_out(strobe_out));

// *** tb/vts_partner.sv ***
module vts_partner #(
  parameter int LCLK  = 8,
  parameter int LINES = 32
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic [3:0]    trig_level,
  output vts_pkg::vts_video_t video,
  output logic [3:0]         trig_in,
  output logic [9:0]         line_no
);
  timeunit 1ns;
  timeprecision 1ps;
  import vts_pkg::*;
  int   pix_q;
  logic field_q;

  // ========================================
  // Video timing, short lines to keep runs brief
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pix_q <= 0;
      line_no <= 10'h000;
      field_q <= 1'b0;
    end else if (pix_q == LCLK - 1) begin
      pix_q <= 0;
      line_no <= (line_no == 10'(LINES - 1)) ? 10'h000 : line_no + 10'h001;
      if (line_no == 10'(LINES - 1)) field_q <= ~field_q;
    end else begin
      pix_q <= pix_q + 1;
    end
  end
  assign video.hsync = (pix_q < 2);
  assign video.vsync = (line_no == 10'h000);
  assign video.vblank = (line_no < 10'h003);
  assign video.field = field_q;
  // Trigger sources drive full-swing levels
  assign trig_in = trig_level;
endmodule

// *** tb/video_synced_trigger_strobe_io_bench.sv ***
module video_synced_trigger_strobe_io_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import vts_pkg::*;
  logic         clk, reset_n, err, done, early;
  vts_apb_req_t req;
  vts_wait_t    wh;
  vts_video_t   video;
  logic [31:0]  prdata, rd;
  logic         pready, pslverr, wait_done;
  logic [1:0]   sel, sv;
  logic [3:0]   strobe, trig, trig_in;
  logic [9:0]   line_no;
  int           fails, comparisons, ticks, pulses;
  logic [7:0]   ra [9] = '{VTS_CTRL, VTS_TYPE, VTS_PLEN, VTS_SYNC, VTS_TWIN, VTS_HMASK,
                           VTS_HSTART, VTS_HLEN, VTS_SELECTOR};
  logic [31:0]  rv [9] = '{32'h1, 32'hff00, 32'h11111111, 32'h0, 32'h0, 32'hf,
                           32'h00080009, 32'h1, 32'h0};

  vts_io i_dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .video(video), .trig_in(trig_in), .wait_head(wh),
    .wait_done(wait_done), .selector_value(sel), .strobe_out(strobe));
  vts_partner i_far (.clk(clk), .reset_n(reset_n), .trig_level(trig), .video(video),
    .trig_in(trig_in), .line_no(line_no));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ========================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held through the edge that samples pready high; answer taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    int n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && n++ < 20);
    rd = prdata;
    err = pslverr;
    req <= '0;
    chk(32'(err), 32'(e));
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rd, exp);
  endtask

  task automatic waitq(input logic [3:0] t, input logic a, input logic [3:0] s,
                       input logic [3:0] m);
    int n = 0;
    @(posedge clk);
    trig <= t;
    wh <= '{valid: 1'b1, all: a, state: s, mask: m};
    do @(posedge clk); while (wait_done !== 1'b1 && n++ < 20);
    done = wait_done;
    sv = sel;
    wh <= '0;
  endtask

  task automatic measure(input int idx, input int cyc);
    logic ph, ps;
    ticks = 0;
    pulses = 0;
    // Sync level of the cycle before, as the design's tick sees it
    ph = video.hsync;
    ps = 1'b0;
    repeat (cyc) begin
      @(negedge clk);
      if (strobe[idx] && video.hsync && !ph) ticks++;
      if (strobe[idx] && !ps) pulses++;
      ph = video.hsync;
      ps = strobe[idx];
    end
  endtask

  task automatic waitline(input logic [9:0] l);
    int n = 0;
    do @(negedge clk); while (line_no !== l && n++ < 2000);
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ========================================
  // Tests
  initial begin
    reset_n = 1'b0;
    req = '0;
    wh = '0;
    trig = 4'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    foreach (ra[i]) rdx(ra[i], rv[i]);
    apb(1'b0, 8'h34, 32'h0, 1'b1);
    chk(rd, 32'h0);
    $display("Test reset_values finished");
    apb(1'b1, VTS_TYPE, 32'h0000ff03, 1'b1);
    apb(1'b1, VTS_TYPE, 32'h0000fe00, 1'b1);
    apb(1'b1, VTS_TYPE, 32'h0000ff06, 1'b0);
    rdx(VTS_TYPE, 32'h0000ff06);
    apb(1'b1, VTS_TYPE, 32'h0000ff00, 1'b0);
    apb(1'b1, VTS_FILTER, 32'h00000311, 1'b0);
    rdx(VTS_FILTER, 32'h00000311);
    apb(1'b1, VTS_FILTER, 32'h0, 1'b0);
    apb(1'b1, VTS_CTRL, 32'h0, 1'b0);
    apb(1'b1, VTS_FILTER, 32'h1, 1'b1);
    apb(1'b1, VTS_CTRL, 32'h1, 1'b0);
    $display("Test config finished");
    apb(1'b1, VTS_STATES, 32'h000000ff, 1'b1);
    apb(1'b1, VTS_STATES, 32'h00003010, 1'b0);
    @(negedge clk);
    chk(32'(strobe), 32'h1);
    rdx(VTS_STATES, 32'h10);
    apb(1'b1, VTS_STATES, 32'h00003000, 1'b0);
    $display("Test direct_write finished");
    waitq(4'h9, 1'b0, 4'hf, 4'hf);
    chk(32'(done), 32'h1);
    chk(32'(sv), 32'h3);
    waitq(4'h9, 1'b0, 4'h0, 4'h2);
    chk(32'(done), 32'h1);
    chk(32'(sv), 32'h0);
    waitq(4'h1, 1'b1, 4'h3, 4'h3);
    chk(32'(done), 32'h0);
    waitq(4'hb, 1'b1, 4'h3, 4'h3);
    chk(32'(done), 32'h1);
    chk(32'(sv), 32'h1);
    apb(1'b1, VTS_CTRL, 32'h3, 1'b0);
    rdx(VTS_SELECTOR, 32'h0);
    $display("Test wait_queue finished");
    apb(1'b1, VTS_PLEN, 32'h03030303, 1'b0);
    apb(1'b1, VTS_HMASK, 32'h0, 1'b0);
    apb(1'b1, VTS_ONE_SHOT, 32'h1, 1'b0);
    measure(0, 150);
    chk(pulses, 1);
    chk(ticks, 3);
    apb(1'b1, VTS_TWIN, 32'h00000201, 1'b0);
    apb(1'b1, VTS_ONE_SHOT, 32'h8, 1'b0);
    measure(3, 200);
    chk(pulses, 2);
    chk(ticks, 6);
    waitline(10'd20);
    apb(1'b1, VTS_SYNC, 32'h000a0001, 1'b0);
    measure(0, 512);
    chk(pulses, 2);
    apb(1'b1, VTS_SYNC, 32'h0, 1'b0);
    measure(0, 600);
    chk(pulses, 0);
    $display("Test pulses finished");
    apb(1'b1, VTS_HMASK, 32'h1, 1'b0);
    apb(1'b1, VTS_HSTART, 32'h00050005, 1'b0);
    apb(1'b1, VTS_HLEN, 32'h4, 1'b0);
    waitline(10'd6);
    apb(1'b1, VTS_ONE_SHOT, 32'h1, 1'b0);
    early = 1'b0;
    while (line_no < 10'd8) begin
      @(negedge clk);
      early = early | strobe[0];
    end
    chk(32'(early), 32'h0);
    measure(0, 100);
    chk(pulses, 1);
    $display("Test holdoff finished");
    apb(1'b1, VTS_HMASK, 32'h0, 1'b0);
    apb(1'b1, VTS_TYPE, 32'h0000ff01, 1'b0);
    apb(1'b1, VTS_TRIG, 32'h2, 1'b0);
    trig <= 4'h0;
    // Low across a vblank, so the vblank sample sees the rise too
    repeat (300) @(posedge clk);
    trig <= 4'h1;
    measure(1, 3);
    chk(pulses, 1);
    repeat (300) @(posedge clk);
    apb(1'b0, VTS_STATES, 32'h0, 1'b0);
    chk(rd & 32'h1, 32'h1);
    apb(1'b1, VTS_STATES, 32'h00000100, 1'b0);
    apb(1'b0, VTS_STATES, 32'h0, 1'b0);
    chk(rd & 32'h1, 32'h0);
    $display("Test trigger finished");
    apb(1'b1, VTS_TYPE, 32'h0000ff00, 1'b0);
    apb(1'b1, VTS_FILTER, 32'h00000001, 1'b0);
    apb(1'b1, VTS_STATES, 32'h00000100, 1'b0);
    rdx(VTS_STATES, 32'h0);
    trig <= 4'h0;
    repeat (300) @(posedge clk);
    trig <= 4'h1;
    rdx(VTS_STATES, 32'h1);
    $display("Test debounce finished");
    test_done();
  end

  // Whole run needs roughly 3000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule
